/* src/dclp_params.svh */
// register indices, field codes and timing constants of the counter, latch and pulse block
`ifndef DCLP_PARAMS_SVH
`define DCLP_PARAMS_SVH

// register indices; byte address is four times the index
`define DCLP_CH5_RUN_IDX      16'h0035
`define DCLP_CH5_CLR_IDX      16'h0036
`define DCLP_CH5_OVF_IDX      16'h0037
`define DCLP_CH5_LATCH_IDX    16'h0038
`define DCLP_CH6_RUN_IDX      16'h0039
`define DCLP_CH6_CLR_IDX      16'h003a
`define DCLP_CH6_OVF_IDX      16'h003b
`define DCLP_CH6_LATCH_IDX    16'h003c
`define DCLP_CH7_RUN_IDX      16'h003d
`define DCLP_CH7_CLR_IDX      16'h003e
`define DCLP_CH7_OVF_IDX      16'h003f
`define DCLP_CH7_LATCH_IDX    16'h0040
`define DCLP_CH8_RUN_IDX      16'h0041
`define DCLP_CH8_CLR_IDX      16'h0042
`define DCLP_CH8_OVF_IDX      16'h0043
`define DCLP_CH8_LATCH_IDX    16'h0044
`define DCLP_CH9_RUN_IDX      16'h0045
`define DCLP_CH9_CLR_IDX      16'h0046
`define DCLP_CH9_OVF_IDX      16'h0047
`define DCLP_CH9_LATCH_IDX    16'h0048
`define DCLP_CH10_RUN_IDX     16'h0049
`define DCLP_CH10_CLR_IDX     16'h004a
`define DCLP_CH10_OVF_IDX     16'h004b
`define DCLP_CH10_LATCH_IDX   16'h004c
`define DCLP_CH11_RUN_IDX     16'h004d
`define DCLP_CH11_CLR_IDX     16'h004e
`define DCLP_CH11_OVF_IDX     16'h004f
`define DCLP_CH11_LATCH_IDX   16'h1f40
`define DCLP_INPUT_WORD_IDX   16'h9d6d
`define DCLP_OUTPUT_WORD_IDX  16'h9d6f
`define DCLP_RULE_FLAGS_IDX   16'h9d71

// additional registers
`define DCLP_CNT_BASE_IDX     16'h0100
`define DCLP_FREQ_MODE_IDX    16'h0120
`define DCLP_LATCH_MODE_IDX   16'h0121
`define DCLP_IRQ_STATUS_IDX   16'h0122
`define DCLP_IRQ_MASK_IDX     16'h0123
`define DCLP_PULSE_BASE_IDX   16'h0130
`define DCLP_PULSE_BUSY_IDX   16'h0140

// pulse channel field offsets within its group of four
`define DCLP_PF_LOW           2'h0
`define DCLP_PF_HIGH          2'h1
`define DCLP_PF_ABS           2'h2
`define DCLP_PF_INC           2'h3

// edge latch codes, two bits per channel
`define DCLP_LATCH_OFF        2'h0
`define DCLP_LATCH_RISE       2'h1
`define DCLP_LATCH_FALL       2'h2

// word reset value, lower counter wrap constant and frequency scale factor
`define DCLP_WORD_RESET       16'h0000
`define DCLP_CNT_LO_WRAP      16'hffff
`define DCLP_FREQ_SCALE       10

// timing
`define DCLP_CLK_PERIOD_NS    10
`define DCLP_PULSE_UNIT_NS    100000
`define DCLP_FREQ_GATE_NS     1000000000

`endif

/* src/dclp_pkg.sv */
// types shared by the counter, latch and pulse block
package dclp_pkg;

  typedef enum logic [1:0]
  {
    DCLP_P_IDLE = 2'b00,
    DCLP_P_LOW  = 2'b01,
    DCLP_P_HIGH = 2'b11
  } dclp_pulse_state_type;

endpackage

/* src/dclp_counter_latch_pulse.sv */
// digital input counters, edge latches, pulse outputs and register slave
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dclp_params.svh"

module dclp_counter_latch_pulse
  import dclp_pkg::*;
#(
  parameter int NPULSE      = 2,
  parameter int UNIT_CYCLES = `DCLP_PULSE_UNIT_NS / `DCLP_CLK_PERIOD_NS,
  parameter int GATE_CYCLES = `DCLP_FREQ_GATE_NS / `DCLP_CLK_PERIOD_NS
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] digital_input,
  output logic      [15:0] output_levels,
  output logic      [15:0] logic_rule_engine_flags,
  output logic [NPULSE-1:0] pulse_out,
  output logic             irq
);

  localparam int NCH = 7;
  localparam int FIRST_CH = 5;

  localparam logic [15:0] RUN_IDX [NCH] = '{`DCLP_CH5_RUN_IDX, `DCLP_CH6_RUN_IDX,
    `DCLP_CH7_RUN_IDX, `DCLP_CH8_RUN_IDX, `DCLP_CH9_RUN_IDX, `DCLP_CH10_RUN_IDX,
    `DCLP_CH11_RUN_IDX};
  localparam logic [15:0] CLR_IDX [NCH] = '{`DCLP_CH5_CLR_IDX, `DCLP_CH6_CLR_IDX,
    `DCLP_CH7_CLR_IDX, `DCLP_CH8_CLR_IDX, `DCLP_CH9_CLR_IDX, `DCLP_CH10_CLR_IDX,
    `DCLP_CH11_CLR_IDX};
  localparam logic [15:0] OVF_IDX [NCH] = '{`DCLP_CH5_OVF_IDX, `DCLP_CH6_OVF_IDX,
    `DCLP_CH7_OVF_IDX, `DCLP_CH8_OVF_IDX, `DCLP_CH9_OVF_IDX, `DCLP_CH10_OVF_IDX,
    `DCLP_CH11_OVF_IDX};
  localparam logic [15:0] LATCH_IDX [NCH] = '{`DCLP_CH5_LATCH_IDX, `DCLP_CH6_LATCH_IDX,
    `DCLP_CH7_LATCH_IDX, `DCLP_CH8_LATCH_IDX, `DCLP_CH9_LATCH_IDX, `DCLP_CH10_LATCH_IDX,
    `DCLP_CH11_LATCH_IDX};

  // index of a counter value word: two words per channel, lower first
  function automatic logic [15:0] cnt_idx(input int k, input logic upper);
    cnt_idx = `DCLP_CNT_BASE_IDX + 16'(2 * k) + {15'h0000, upper};
  endfunction

  function automatic logic [15:0] pulse_idx(input int p, input logic [1:0] field);
    pulse_idx = `DCLP_PULSE_BASE_IDX + 16'(4 * p) + {14'h0000, field};
  endfunction

  // a zero width is stretched to one unit so a phase never vanishes
  function automatic logic [31:0] phase_cycles(input logic [15:0] w);
    logic [31:0] units;
    units = (w == 16'h0000) ? 32'h0000_0001 : {16'h0000, w};
    phase_cycles = units * 32'(UNIT_CYCLES);
  endfunction

  function automatic logic [15:0] scale_freq(input logic [15:0] edges);
    logic [19:0] prod;
    prod = 20'(edges) * 20'(`DCLP_FREQ_SCALE);
    scale_freq = (prod > 20'h0_ffff) ? 16'hffff : prod[15:0];
  endfunction

  // bus decode
  logic [15:0] idx;
  logic        setup_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [31:0] next_prdata;
  logic        rd_hit_q;

  assign idx      = paddr[17:2];
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign pready   = 1'b1;

  // register state
  logic [NCH-1:0]   run;
  logic [NCH-1:0]   ovf;
  logic [NCH-1:0]   latch;
  logic [NCH-1:0]   freq_mode;
  logic [2*NCH-1:0] latch_mode;
  logic [15:0]      cnt_lo [NCH];
  logic [15:0]      cnt_hi [NCH];
  logic [15:0]      freq_edges [NCH];
  logic [31:0]      gate_cnt;
  logic [2*NCH-1:0] irq_status;
  logic [2*NCH-1:0] irq_mask;
  logic [15:0]      di_prev;
  logic [15:0]      p_low  [NPULSE];
  logic [15:0]      p_high [NPULSE];
  logic [31:0]      p_abs  [NPULSE];
  logic [31:0]      p_inc  [NPULSE];
  logic [31:0]      p_left [NPULSE];
  logic [31:0]      p_timer [NPULSE];
  logic [NPULSE-1:0] p_cont;
  dclp_pulse_state_type p_state [NPULSE];

  // events
  logic [15:0]      rise;
  logic [15:0]      fall;
  logic [NCH-1:0]   ovf_evt;
  logic [NCH-1:0]   latch_evt;
  logic             gate_end;

  assign rise     = digital_input & ~di_prev;
  assign fall     = ~digital_input & di_prev;
  assign gate_end = (gate_cnt == 32'(GATE_CYCLES - 1));

  always_comb
  begin
    for (int k = 0; k < NCH; k++)
    begin
      ovf_evt[k] = !freq_mode[k] && run[k] && rise[k + FIRST_CH] &&
                   (cnt_lo[k] == `DCLP_CNT_LO_WRAP - 16'h0001) &&
                   (cnt_hi[k] == 16'hffff);
      latch_evt[k] = ((latch_mode[2*k +: 2] == `DCLP_LATCH_RISE) && rise[k + FIRST_CH]) ||
                     ((latch_mode[2*k +: 2] == `DCLP_LATCH_FALL) && fall[k + FIRST_CH]);
    end
  end

  // read mux and decode of mapped indices
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    hit         = 1'b0;
    for (int k = 0; k < NCH; k++)
    begin
      if (idx == RUN_IDX[k])
      begin
        next_prdata = {31'h0, run[k]};
        hit         = 1'b1;
      end
      if (idx == CLR_IDX[k])
        hit = 1'b1;
      if (idx == OVF_IDX[k])
      begin
        next_prdata = {31'h0, ovf[k]};
        hit         = 1'b1;
      end
      if (idx == LATCH_IDX[k])
      begin
        next_prdata = {31'h0, latch[k]};
        hit         = 1'b1;
      end
      if (idx == cnt_idx(k, 1'b0))
      begin
        next_prdata = {16'h0000, cnt_lo[k]};
        hit         = 1'b1;
      end
      if (idx == cnt_idx(k, 1'b1))
      begin
        next_prdata = {16'h0000, cnt_hi[k]};
        hit         = 1'b1;
      end
    end
    for (int p = 0; p < NPULSE; p++)
    begin
      if (idx == pulse_idx(p, `DCLP_PF_LOW))
      begin
        next_prdata = {16'h0000, p_low[p]};
        hit         = 1'b1;
      end
      if (idx == pulse_idx(p, `DCLP_PF_HIGH))
      begin
        next_prdata = {16'h0000, p_high[p]};
        hit         = 1'b1;
      end
      if (idx == pulse_idx(p, `DCLP_PF_ABS))
      begin
        next_prdata = p_abs[p];
        hit         = 1'b1;
      end
      if (idx == pulse_idx(p, `DCLP_PF_INC))
      begin
        next_prdata = p_inc[p];
        hit         = 1'b1;
      end
    end
    case (idx)
      `DCLP_INPUT_WORD_IDX:
      begin
        next_prdata = {16'h0000, digital_input};
        hit         = 1'b1;
      end
      `DCLP_OUTPUT_WORD_IDX:
      begin
        next_prdata = {16'h0000, output_levels};
        hit         = 1'b1;
      end
      `DCLP_RULE_FLAGS_IDX:
      begin
        next_prdata = {16'h0000, logic_rule_engine_flags};
        hit         = 1'b1;
      end
      `DCLP_FREQ_MODE_IDX:
      begin
        next_prdata = {25'h0, freq_mode};
        hit         = 1'b1;
      end
      `DCLP_LATCH_MODE_IDX:
      begin
        next_prdata = {18'h0, latch_mode};
        hit         = 1'b1;
      end
      `DCLP_IRQ_STATUS_IDX:
      begin
        next_prdata = {18'h0, irq_status};
        hit         = 1'b1;
      end
      `DCLP_IRQ_MASK_IDX:
      begin
        next_prdata = {18'h0, irq_mask};
        hit         = 1'b1;
      end
      `DCLP_PULSE_BUSY_IDX:
      begin
        for (int p = 0; p < NPULSE; p++)
          next_prdata[p] = (p_state[p] != DCLP_P_IDLE);
        hit = 1'b1;
      end
      default:
      begin
      end
    endcase
  end

  // read data is captured in the setup phase; read-clear acts on what was captured
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata   <= 32'h0000_0000;
      rd_hit_q <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata   <= (pwrite || !hit || paddr[1:0] != 2'b00) ? 32'h0000_0000 : next_prdata;
      rd_hit_q <= hit;
    end
  end

  assign pslverr = psel && penable && (!rd_hit_q || (paddr[1:0] != 2'b00));

  logic acc_ok;
  assign acc_ok = !pslverr;

  // control words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run           <= '0;
      freq_mode     <= '0;
      latch_mode    <= '0;
      irq_mask      <= '0;
      output_levels <= `DCLP_WORD_RESET;
      logic_rule_engine_flags <= `DCLP_WORD_RESET;
    end
    else if (wr_acc && acc_ok)
    begin
      for (int k = 0; k < NCH; k++)
        if (idx == RUN_IDX[k] && pstrb[0])
          run[k] <= pwdata[0];
      if (pstrb[0] && idx == `DCLP_FREQ_MODE_IDX)
        freq_mode <= pwdata[NCH-1:0];
      if (idx == `DCLP_LATCH_MODE_IDX)
        latch_mode <= pwdata[2*NCH-1:0];
      if (idx == `DCLP_IRQ_MASK_IDX)
        irq_mask <= pwdata[2*NCH-1:0];
      if (idx == `DCLP_OUTPUT_WORD_IDX)
        output_levels <= pwdata[15:0];
      if (idx == `DCLP_RULE_FLAGS_IDX)
        logic_rule_engine_flags <= pwdata[15:0];
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf        <= '0;
      latch      <= '0;
      irq_status <= '0;
    end
    else
    begin
      for (int k = 0; k < NCH; k++)
      begin
        if (ovf_evt[k])
          ovf[k] <= 1'b1;
        else if (rd_acc && acc_ok && idx == OVF_IDX[k] && prdata[0])
          ovf[k] <= 1'b0;
        if (latch_evt[k])
          latch[k] <= 1'b1;
        else if (wr_acc && acc_ok && idx == LATCH_IDX[k] && pstrb[0] && !pwdata[0])
          latch[k] <= 1'b0;
      end
      for (int b = 0; b < 2*NCH; b++)
      begin
        if ((b < NCH) ? ovf_evt[b % NCH] : latch_evt[b % NCH])
          irq_status[b] <= 1'b1;
        else if (rd_acc && acc_ok && idx == `DCLP_IRQ_STATUS_IDX && prdata[b])
          irq_status[b] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // counters and frequency gate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      di_prev  <= '0;
      gate_cnt <= '0;
      for (int k = 0; k < NCH; k++)
      begin
        cnt_lo[k]     <= '0;
        cnt_hi[k]     <= '0;
        freq_edges[k] <= '0;
      end
    end
    else
    begin
      di_prev  <= digital_input;
      gate_cnt <= gate_end ? 32'h0000_0000 : gate_cnt + 32'h0000_0001;
      for (int k = 0; k < NCH; k++)
      begin
        if (gate_end)
          freq_edges[k] <= {15'h0000, rise[k + FIRST_CH]};
        else if (rise[k + FIRST_CH] && freq_edges[k] != 16'hffff)
          freq_edges[k] <= freq_edges[k] + 16'h0001;
        if (wr_acc && acc_ok && idx == CLR_IDX[k] && pwdata[0])
        begin
          cnt_lo[k] <= '0;
          cnt_hi[k] <= '0;
        end
        else if (freq_mode[k])
        begin
          if (gate_end)
          begin
            cnt_lo[k] <= scale_freq(freq_edges[k]);
            cnt_hi[k] <= '0;
          end
        end
        else if (run[k] && rise[k + FIRST_CH])
        begin
          if (cnt_lo[k] == `DCLP_CNT_LO_WRAP - 16'h0001)
          begin
            cnt_lo[k] <= '0;
            cnt_hi[k] <= cnt_hi[k] + 16'h0001;
          end
          else
            cnt_lo[k] <= cnt_lo[k] + 16'h0001;
        end
      end
    end
  end

  // per-channel write strobes and pulse budget with an incremental count added only while the channel is busy
  logic [NPULSE-1:0] abs_wr;
  logic [NPULSE-1:0] inc_wr;
  logic [31:0]       left_sum [NPULSE];

  always_comb
  begin
    for (int p = 0; p < NPULSE; p++)
    begin
      abs_wr[p]   = wr_acc && acc_ok && idx == pulse_idx(p, `DCLP_PF_ABS);
      inc_wr[p]   = wr_acc && acc_ok && idx == pulse_idx(p, `DCLP_PF_INC);
      left_sum[p] = p_left[p] +
                    ((inc_wr[p] && p_state[p] != DCLP_P_IDLE) ? pwdata : 32'h0000_0000);
    end
  end

  // pulse generators
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p_cont <= '0;
      for (int p = 0; p < NPULSE; p++)
      begin
        p_low[p]   <= '0;
        p_high[p]  <= '0;
        p_abs[p]   <= '0;
        p_inc[p]   <= '0;
        p_left[p]  <= '0;
        p_timer[p] <= '0;
        p_state[p] <= DCLP_P_IDLE;
      end
    end
    else
    begin
      for (int p = 0; p < NPULSE; p++)
      begin
        if (wr_acc && acc_ok && idx == pulse_idx(p, `DCLP_PF_LOW))
          p_low[p] <= pwdata[15:0];
        if (wr_acc && acc_ok && idx == pulse_idx(p, `DCLP_PF_HIGH))
          p_high[p] <= pwdata[15:0];
        if (inc_wr[p])
          p_inc[p] <= pwdata;
        if (abs_wr[p])
        begin
          p_abs[p]   <= pwdata;
          p_left[p]  <= pwdata;
          p_cont[p]  <= (pwdata == 32'h0000_0000);
          p_timer[p] <= phase_cycles(p_low[p]);
          p_state[p] <= DCLP_P_LOW;
        end
        else
        begin
          case (p_state[p])
            DCLP_P_IDLE:
            begin
              p_left[p] <= '0;
            end
            DCLP_P_LOW:
            begin
              p_left[p] <= left_sum[p];
              if (p_timer[p] <= 32'h0000_0001)
              begin
                p_timer[p] <= phase_cycles(p_high[p]);
                p_state[p] <= DCLP_P_HIGH;
              end
              else
                p_timer[p] <= p_timer[p] - 32'h0000_0001;
            end
            DCLP_P_HIGH:
            begin
              if (p_timer[p] > 32'h0000_0001)
              begin
                p_timer[p] <= p_timer[p] - 32'h0000_0001;
                p_left[p]  <= left_sum[p];
              end
              else if (p_cont[p] || left_sum[p] > 32'h0000_0001)
              begin
                p_left[p]  <= p_cont[p] ? left_sum[p] : left_sum[p] - 32'h0000_0001;
                p_timer[p] <= phase_cycles(p_low[p]);
                p_state[p] <= DCLP_P_LOW;
              end
              else
              begin
                p_left[p]  <= '0;
                p_state[p] <= DCLP_P_IDLE;
              end
            end
            default:
            begin
              p_state[p] <= DCLP_P_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < NPULSE; p++)
      pulse_out[p] = p_state[p][1];
  end

endmodule // dclp_counter_latch_pulse

`default_nettype wire

/* bench/dclp_counter_latch_pulse_props.sv */
// port assertions for the counter, latch and pulse block
`timescale 1ns/1ps
`default_nettype none
`include "dclp_params.svh"
module dclp_checker
#(
  parameter int NPULSE      = 2,
  parameter int UNIT_CYCLES = 2
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [17:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       digital_input,
  input wire logic [15:0]       output_levels,
  input wire logic [15:0]       logic_rule_engine_flags,
  input wire logic [NPULSE-1:0] pulse_out,
  input wire logic              irq
);
  default clocking dclp_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic        acc;
  logic        wo;
  logic        wf;
  logic [15:0] wd;
  int          hcnt;
  assign acc = psel && penable;
  assign wo  = acc && pwrite && paddr == {`DCLP_OUTPUT_WORD_IDX, 2'b00};
  assign wf  = acc && pwrite && paddr == {`DCLP_RULE_FLAGS_IDX, 2'b00};
  assign wd  = pwdata[15:0];
  // length of the running high phase of pulse channel 0
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hcnt <= 0;
    else if (pulse_out[0])
      hcnt <= hcnt + 1;
    else
      hcnt <= 0;
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err_phase;
    pslverr |-> acc;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_align;
    acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err_align: assert property (p_err_align) else $error("misaligned not refused");
  property p_out_write;
    wo |=> output_levels == $past(wd);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output word not written");
  property p_out_hold;
    !wo |=> $stable(output_levels);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word changed");
  property p_flag_write;
    wf |=> logic_rule_engine_flags == $past(wd);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag word not written");
  property p_flag_hold;
    !wf |=> $stable(logic_rule_engine_flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag word changed");
  property p_pulse_high;
    $fell(pulse_out[0]) |-> hcnt > 0 && hcnt % UNIT_CYCLES == 0;
  endproperty
  a_pulse_high: assert property (p_pulse_high) else $error("high phase not whole units");
endmodule // dclp_checker
`default_nettype wire

/* bench/tb_dclp_counter_latch_pulse.sv */
// register level testbench of the counter, latch and pulse block
`timescale 1ns/1ps
`default_nettype none
`include "dclp_params.svh"
module tb_dclp_counter_latch_pulse;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  logic [15:0] di, output_levels, logic_rule_engine_flags;
  logic [1:0]  pulse_out;
  int          n_mismatch, checks_done, r0;
  int          rises = 0;
  int          hrun = 0;
  int          hw = 0;
  dclp_counter_latch_pulse #(.NPULSE(2), .UNIT_CYCLES(2), .GATE_CYCLES(100)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_input(di), .output_levels(output_levels),
    .logic_rule_engine_flags(logic_rule_engine_flags), .pulse_out(pulse_out), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // counts pulses and keeps the last high width of pulse channel 0
  always @(posedge pclk)
  begin
    hrun <= (pulse_out[0] === 1'b1) ? hrun + 1 : 0;
    if (pulse_out[0] === 1'b0 && hrun > 0)
      hw <= hrun;
    if (pulse_out[0] === 1'b1 && hrun == 0)
      rises <= rises + 1;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    xfer(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rc(input string nm, input logic [15:0] i, input logic [31:0] e);
    xfer(1'b0, {i, 2'b00}, 32'h0000_0000);
    chk(nm, rv, e);
  endtask
  task automatic edges(input int b, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      di[b] <= 1'b1;
      @(posedge pclk);
      di[b] <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, di} = '0;
    pstrb = 4'hf;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq", 32'(irq), 32'h0000_0000);
    rc("out", `DCLP_OUTPUT_WORD_IDX, 32'h0000_0000);
    rc("run", `DCLP_CH5_RUN_IDX, 32'h0000_0000);
    $display("test reset done");
    di <= 16'h1234;
    wr(`DCLP_OUTPUT_WORD_IDX, 32'h0000_a5c3);
    chk("out pin", 32'(output_levels), 32'h0000_a5c3);
    rc("out", `DCLP_OUTPUT_WORD_IDX, 32'h0000_a5c3);
    wr(`DCLP_RULE_FLAGS_IDX, 32'h0000_5a3c);
    rc("flags", `DCLP_RULE_FLAGS_IDX, 32'h0000_5a3c);
    wr(`DCLP_INPUT_WORD_IDX, 32'h0000_ffff);
    rc("in", `DCLP_INPUT_WORD_IDX, 32'h0000_1234);
    xfer(1'b0, 18'h0_0800, 32'h0000_0000);
    chk("unmapped", 32'(er), 32'h0000_0001);
    xfer(1'b1, {`DCLP_OUTPUT_WORD_IDX, 2'b01}, 32'h0000_0000);
    chk("misaligned", 32'(er), 32'h0000_0001);
    xfer(1'b0, {`DCLP_OUTPUT_WORD_IDX, 2'b10}, 32'h0000_0000);
    chk("misaligned rd", rv, 32'h0000_0000);
    chk("misaligned rd err", 32'(er), 32'h0000_0001);
    rc("out kept", `DCLP_OUTPUT_WORD_IDX, 32'h0000_a5c3);
    di <= 16'h0000;
    $display("test words done");
    for (int k = 0; k < 7; k++)
    begin
      wr(`DCLP_CH5_RUN_IDX + 16'(4 * k), 32'h0000_0001);
      edges(5 + k, k + 1);
      rc("count", `DCLP_CNT_BASE_IDX + 16'(2 * k), 32'(k + 1));
      rc("upper", `DCLP_CNT_BASE_IDX + 16'(2 * k + 1), 32'h0000_0000);
    end
    rc("run", `DCLP_CH5_RUN_IDX, 32'h0000_0001);
    wr(`DCLP_CH5_RUN_IDX, 32'h0000_0000);
    edges(5, 3);
    rc("frozen", `DCLP_CNT_BASE_IDX, 32'h0000_0001);
    wr(`DCLP_CH5_CLR_IDX, 32'h0000_0001);
    rc("cleared", `DCLP_CNT_BASE_IDX, 32'h0000_0000);
    rc("overflow", `DCLP_CH5_OVF_IDX, 32'h0000_0000);
    $display("test counters done");
    wr(`DCLP_LATCH_MODE_IDX, 32'h0000_1009);
    wr(`DCLP_IRQ_MASK_IDX, 32'h0000_0080);
    edges(6, 1);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    rc("latch6", `DCLP_CH6_LATCH_IDX, 32'h0000_0001);
    edges(5, 1);
    chk("irq", 32'(irq), 32'h0000_0001);
    rc("latch5", `DCLP_CH5_LATCH_IDX, 32'h0000_0001);
    edges(11, 1);
    rc("latch11", `DCLP_CH11_LATCH_IDX, 32'h0000_0001);
    wr(`DCLP_CH5_LATCH_IDX, 32'h0000_0001);
    rc("latch held", `DCLP_CH5_LATCH_IDX, 32'h0000_0001);
    wr(`DCLP_CH5_LATCH_IDX, 32'h0000_0000);
    rc("latch clr", `DCLP_CH5_LATCH_IDX, 32'h0000_0000);
    rc("status", `DCLP_IRQ_STATUS_IDX, 32'h0000_2180);
    rc("status clr", `DCLP_IRQ_STATUS_IDX, 32'h0000_0000);
    chk("irq clr", 32'(irq), 32'h0000_0000);
    $display("test latches done");
    wr(`DCLP_PULSE_BASE_IDX, 32'h0000_0001);
    wr(`DCLP_PULSE_BASE_IDX + 16'h0001, 32'h0000_0002);
    r0 = rises;
    wr(`DCLP_PULSE_BASE_IDX + 16'h0002, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    chk("pulses", 32'(rises - r0), 32'h0000_0003);
    chk("high width", 32'(hw), 32'h0000_0004);
    rc("idle", `DCLP_PULSE_BUSY_IDX, 32'h0000_0000);
    r0 = rises;
    wr(`DCLP_PULSE_BASE_IDX + 16'h0002, 32'h0000_0002);
    wr(`DCLP_PULSE_BASE_IDX + 16'h0003, 32'h0000_0002);
    repeat (18) @(posedge pclk);
    chk("no gap", 32'(rises - r0), 32'h0000_0004);
    repeat (20) @(posedge pclk);
    chk("added", 32'(rises - r0), 32'h0000_0004);
    r0 = rises;
    wr(`DCLP_PULSE_BASE_IDX + 16'h0002, 32'h0000_0000);
    repeat (60) @(posedge pclk);
    chk("endless", 32'(rises - r0 >= 9), 32'h0000_0001);
    rc("busy", `DCLP_PULSE_BUSY_IDX, 32'h0000_0001);
    wr(`DCLP_PULSE_BASE_IDX + 16'h0006, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("pulse1", 32'(pulse_out[1]), 32'h0000_0001);
    @(posedge pclk);
    rc("busy0", `DCLP_PULSE_BUSY_IDX, 32'h0000_0001);
    $display("test pulses done");
    wr(`DCLP_FREQ_MODE_IDX, 32'h0000_0001);
    fork
      repeat (70)
      begin
        repeat (5) @(posedge pclk);
        di[5] <= ~di[5];
      end
    join_none
    repeat (260) @(posedge pclk);
    rc("freq", `DCLP_CNT_BASE_IDX, 32'h0000_0064);
    rc("freq upper", `DCLP_CNT_BASE_IDX + 16'h0001, 32'h0000_0000);
    $display("test frequency done");
    stop_test;
  end
endmodule // tb_dclp_counter_latch_pulse
bind dclp_counter_latch_pulse dclp_checker #(.NPULSE(NPULSE), .UNIT_CYCLES(UNIT_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .digital_input(digital_input), .output_levels(output_levels),
  .logic_rule_engine_flags(logic_rule_engine_flags), .pulse_out(pulse_out), .irq(irq));
`default_nettype wire
